/* hw/switch_operation_mode_control.sv */
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Sleep: all channels off, all registers held at reset values.
// - Idle: channels off, diagnosis disabled.
// - Idle with logic supply: registers usable, transfers accepted.
// - Idle keeps latched error bits.
// - Wake high plus any input or channel bit: go active.
// - Stay-active 0: active returns to idle when inputs and bits clear.
// - Stay-active 1: remain active regardless of inputs and bits.
// - Logic undervoltage moves active to idle if inputs low.
// - High input forces active even with both maps zero.
// - Wake low plus high input: fallback, mapped channel on.
// - Fallback: reads answered, writes ignored.
// - Fallback entry forces supply undervoltage and low-power flags.
// - Fallback reports operating-state field 01.
// - First command after fallback entry sets transfer error flag.
// - Fallback: off-load bits zero, errors and monitor keep working.
// - Fallback: other registers default and not programmable.
// - Fallback: only channels 2 and 3, via inputs.
// - Power-on when input or wake high and a supply is good.
// - Registers reset on logic supply loss, wake low, or soft reset.
// - Soft reset keeps error bits, clears supply and power flags.
// - Register reset restores maps; channels off unless input high.
// - Turn-on request when not active goes active or fallback.
module switch_operation_mode_control (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic reset_i, // Async reset, high
  input wire logic wake_i, // Wake pin, async
  input wire logic [1:0] direct_input_pins_i, // Direct inputs, async
  input wire logic vdd_ok_i, // Logic supply above undervoltage
  input wire logic vdd_full_i, // Logic supply above low-power range
  input wire logic vs_ok_i, // Load supply above operating level
  input wire logic vs_uv_i, // Load supply undervoltage event
  input wire logic [7:0] err_set_i, // Per-channel error events
  input wire logic [7:0] off_load_i, // Off-state open-load results
  input wire logic [7:0] monitor_i, // Output monitor levels
  input wire logic [3:0] addr_i, // Register index
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  output logic [7:0] channel_o, // Channel drive
  output logic [1:0] mode_o, // Operating-state code
  output logic diag_en_o, // Diagnosis enable
  output logic power_on_o // Internal power-on
);

  typedef struct packed {
    mode_ctrl_pkg::op_state_t st;
    logic [2:0] wake_s;
    logic wake_v;
    logic [1:0] in_s1;
    logic [1:0] in_s2;
    logic [1:0] in_s3;
    logic [1:0] in_v;
    logic [7:0] chan_on;
    logic stay_active;
    logic [7:0] map_first;
    logic [7:0] map_second;
    logic [7:0] err;
    logic supply_uv;
    logic low_power;
    logic xfer_err;
    logic xfer_pend;
    logic [7:0] rdata;
    logic [7:0] chan;
  } state_t;

  state_t q, d;

  logic in_any;
  logic on_any;
  logic regs_ok;
  logic soft_rst;
  logic reg_rst;
  logic wr_ok;
  logic status_rd;
  logic [7:0] mapped;
  logic [7:0] status;
  logic [1:0] code;

  // Mapped input drive, one term per direct input
  always_comb begin
    mapped = 8'h00;
    if (q.in_v[0]) begin
      mapped = mapped | q.map_first;
    end
    if (q.in_v[1]) begin
      mapped = mapped | q.map_second;
    end
  end

  // Decode helpers
  always_comb begin
    in_any = |q.in_v;
    on_any = |q.chan_on;
    regs_ok = vdd_ok_i && (q.st != mode_ctrl_pkg::ST_SLEEP);
    wr_ok = wr_i && regs_ok && (q.st != mode_ctrl_pkg::ST_FALLBACK);
    soft_rst = wr_ok && (addr_i == mode_ctrl_pkg::ADDR_HW_CTRL)
               && wdata_i[mode_ctrl_pkg::HW_SOFT_RESET_POS];
    // Wake low also covers sleep and fallback holding defaults
    reg_rst = !vdd_ok_i || !q.wake_v || soft_rst;
    status_rd = rd_i && regs_ok && (addr_i == mode_ctrl_pkg::ADDR_STATUS);
    case (q.st)
      mode_ctrl_pkg::ST_SLEEP: code = mode_ctrl_pkg::CODE_SLEEP;
      mode_ctrl_pkg::ST_IDLE: code = mode_ctrl_pkg::CODE_IDLE;
      mode_ctrl_pkg::ST_ACTIVE: code = mode_ctrl_pkg::CODE_ACTIVE;
      mode_ctrl_pkg::ST_FALLBACK: code = mode_ctrl_pkg::CODE_FALLBACK;
      default: code = mode_ctrl_pkg::CODE_SLEEP;
    endcase
    status = 8'h00;
    status[mode_ctrl_pkg::ST_MODE_POS +: 2] = code;
    status[mode_ctrl_pkg::ST_SUPPLY_UV_POS] = q.supply_uv;
    status[mode_ctrl_pkg::ST_LOW_POWER_POS] = q.low_power;
    // A pending first-command error shows on that very command
    status[mode_ctrl_pkg::ST_XFER_ERR_POS] = q.xfer_err | q.xfer_pend;
  end

  // Next-state logic for the whole block
  always_comb begin
    d = q;

    // Three-stage synchronisers; a change counts when stages 2 and 3 agree
    d.wake_s = {q.wake_s[1:0], wake_i};
    if (q.wake_s[1] == q.wake_s[2]) begin
      d.wake_v = q.wake_s[2];
    end
    d.in_s1 = direct_input_pins_i;
    d.in_s2 = q.in_s1;
    d.in_s3 = q.in_s2;
    for (int i = 0; i < 2; i++) begin
      if (q.in_s2[i] == q.in_s3[i]) begin
        d.in_v[i] = q.in_s3[i];
      end
    end

    // Operating-state transitions
    case (q.st)
      mode_ctrl_pkg::ST_SLEEP, mode_ctrl_pkg::ST_IDLE: begin
        if (!q.wake_v && in_any) begin
          d.st = mode_ctrl_pkg::ST_FALLBACK;
        end else if (!q.wake_v) begin
          d.st = mode_ctrl_pkg::ST_SLEEP;
        end else if (in_any || on_any) begin
          d.st = mode_ctrl_pkg::ST_ACTIVE;
        end else begin
          d.st = mode_ctrl_pkg::ST_IDLE;
        end
      end
      mode_ctrl_pkg::ST_ACTIVE: begin
        if (!q.wake_v && in_any) begin
          d.st = mode_ctrl_pkg::ST_FALLBACK;
        end else if (!q.wake_v) begin
          d.st = mode_ctrl_pkg::ST_SLEEP;
        end else if (!vdd_ok_i && !in_any) begin
          d.st = mode_ctrl_pkg::ST_IDLE;
        end else if (q.stay_active) begin
          d.st = mode_ctrl_pkg::ST_ACTIVE;
        end else if (!in_any && !on_any) begin
          d.st = mode_ctrl_pkg::ST_IDLE;
        end
      end
      mode_ctrl_pkg::ST_FALLBACK: begin
        if (q.wake_v) begin
          // Leaving fallback; a turn-on request decides active or idle
          d.st = in_any ? mode_ctrl_pkg::ST_ACTIVE : mode_ctrl_pkg::ST_IDLE;
        end else if (!in_any) begin
          d.st = mode_ctrl_pkg::ST_SLEEP;
        end
      end
      default: d.st = mode_ctrl_pkg::ST_SLEEP;
    endcase

    // Register writes, only where writes are accepted
    if (wr_ok) begin
      case (addr_i)
        mode_ctrl_pkg::ADDR_CHAN_ON: d.chan_on = wdata_i;
        mode_ctrl_pkg::ADDR_HW_CTRL: begin
          d.stay_active = wdata_i[mode_ctrl_pkg::HW_STAY_ACTIVE_POS];
        end
        mode_ctrl_pkg::ADDR_MAP_FIRST: d.map_first = wdata_i;
        mode_ctrl_pkg::ADDR_MAP_SECOND: d.map_second = wdata_i;
        default: d.chan_on = q.chan_on;
      endcase
    end

    // Register reset restores defaults; soft reset bit never stores
    if (reg_rst) begin
      d.chan_on = mode_ctrl_pkg::CHAN_ON_RST;
      d.stay_active = 1'b0;
      d.map_first = mode_ctrl_pkg::MAP_FIRST_RST;
      d.map_second = mode_ctrl_pkg::MAP_SECOND_RST;
    end

    // Supply flags: clear on status read or soft reset, a new event wins
    if (status_rd && vs_ok_i) begin
      d.supply_uv = 1'b0;
    end
    if (status_rd && vdd_full_i) begin
      d.low_power = 1'b0;
    end
    if (soft_rst || !vdd_ok_i || !q.wake_v) begin
      d.supply_uv = 1'b0;
      d.low_power = 1'b0;
    end
    if (vs_uv_i && q.st != mode_ctrl_pkg::ST_SLEEP) begin
      d.supply_uv = 1'b1;
    end
    if (vdd_ok_i && !vdd_full_i && q.st != mode_ctrl_pkg::ST_SLEEP) begin
      d.low_power = 1'b1;
    end
    // Fallback forces both flags, held for its whole stay
    if (d.st == mode_ctrl_pkg::ST_FALLBACK) begin
      d.supply_uv = 1'b1;
      d.low_power = 1'b1;
    end

    // Transfer error: armed on fallback entry, fired by first command
    if (status_rd) begin
      d.xfer_err = 1'b0;
    end
    if ((rd_i || wr_i) && q.xfer_pend) begin
      d.xfer_err = 1'b1;
      d.xfer_pend = 1'b0;
    end
    if (d.st == mode_ctrl_pkg::ST_FALLBACK && q.st != mode_ctrl_pkg::ST_FALLBACK) begin
      d.xfer_pend = 1'b1;
    end
    if (d.st == mode_ctrl_pkg::ST_SLEEP || !vdd_ok_i) begin
      d.xfer_err = 1'b0;
      d.xfer_pend = 1'b0;
    end

    // Latched errors: write one to clear, events win; soft reset keeps them
    if (wr_ok && addr_i == mode_ctrl_pkg::ADDR_ERR) begin
      d.err = q.err & ~wdata_i;
    end
    if (q.st == mode_ctrl_pkg::ST_ACTIVE || q.st == mode_ctrl_pkg::ST_FALLBACK) begin
      d.err = d.err | err_set_i;
    end
    // Only sleep or lost logic supply wipes them, idle holds them
    if (q.st == mode_ctrl_pkg::ST_SLEEP || !vdd_ok_i) begin
      d.err = 8'h00;
    end

    // Read data, valid only in the cycle after the strobe
    d.rdata = 8'h00;
    if (rd_i && regs_ok) begin
      case (addr_i)
        mode_ctrl_pkg::ADDR_CHAN_ON: d.rdata = q.chan_on;
        mode_ctrl_pkg::ADDR_HW_CTRL: begin
          d.rdata[mode_ctrl_pkg::HW_STAY_ACTIVE_POS] = q.stay_active;
        end
        mode_ctrl_pkg::ADDR_MAP_FIRST: d.rdata = q.map_first;
        mode_ctrl_pkg::ADDR_MAP_SECOND: d.rdata = q.map_second;
        mode_ctrl_pkg::ADDR_STATUS: d.rdata = status;
        mode_ctrl_pkg::ADDR_ERR: d.rdata = q.err;
        mode_ctrl_pkg::ADDR_OFF_LOAD: begin
          // No off-state check runs in fallback
          if (q.st != mode_ctrl_pkg::ST_FALLBACK) begin
            d.rdata = off_load_i;
          end
        end
        mode_ctrl_pkg::ADDR_MONITOR: d.rdata = monitor_i;
        default: d.rdata = 8'h00;
      endcase
    end

    // Channel drive follows the state just decided
    case (d.st)
      mode_ctrl_pkg::ST_ACTIVE: d.chan = d.chan_on | mapped;
      mode_ctrl_pkg::ST_FALLBACK: d.chan = mapped & mode_ctrl_pkg::FALLBACK_CHAN_MASK;
      default: d.chan = 8'h00;
    endcase
  end

  // Single state register
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '{
        st: mode_ctrl_pkg::ST_SLEEP,
        map_first: mode_ctrl_pkg::MAP_FIRST_RST,
        map_second: mode_ctrl_pkg::MAP_SECOND_RST,
        chan_on: mode_ctrl_pkg::CHAN_ON_RST,
        default: '0
      };
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign rdata_o = q.rdata;
  assign channel_o = q.chan;
  assign mode_o = code;
  assign diag_en_o = (q.st == mode_ctrl_pkg::ST_ACTIVE);
  // Power-on is combinational from supplies and the filtered pins
  assign power_on_o = (in_any || q.wake_v) && (vs_ok_i || vdd_full_i);

endmodule

/* hw/mode_ctrl_pkg.sv */
package mode_ctrl_pkg;
  // Register indexes on the plain register port
  localparam logic [3:0] ADDR_CHAN_ON = 4'h0;
  localparam logic [3:0] ADDR_HW_CTRL = 4'h1;
  localparam logic [3:0] ADDR_MAP_FIRST = 4'h2;
  localparam logic [3:0] ADDR_MAP_SECOND = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_ERR = 4'h5;
  localparam logic [3:0] ADDR_OFF_LOAD = 4'h6;
  localparam logic [3:0] ADDR_MONITOR = 4'h7;
  // Control register field positions
  localparam int HW_STAY_ACTIVE_POS = 0;
  localparam int HW_SOFT_RESET_POS = 1;
  // Status register field positions
  localparam int ST_MODE_POS = 0;
  localparam int ST_SUPPLY_UV_POS = 2;
  localparam int ST_LOW_POWER_POS = 3;
  localparam int ST_XFER_ERR_POS = 4;
  // Reset values and fallback channel mask
  localparam logic [7:0] CHAN_ON_RST = 8'h00;
  localparam logic [7:0] MAP_FIRST_RST = 8'h04;
  localparam logic [7:0] MAP_SECOND_RST = 8'h08;
  localparam logic [7:0] FALLBACK_CHAN_MASK = 8'h0c;
  // Operating-state field codes
  localparam logic [1:0] CODE_SLEEP = 2'h0;
  localparam logic [1:0] CODE_FALLBACK = 2'h1;
  localparam logic [1:0] CODE_IDLE = 2'h2;
  localparam logic [1:0] CODE_ACTIVE = 2'h3;

  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_IDLE,
    ST_ACTIVE,
    ST_FALLBACK
  } op_state_t;
endpackage

/* dv/mode_ctrl_chk.sv */
`timescale 1ns/1ps
// Pin-level checks of state, channel and read port
module mode_ctrl_chk (
  input wire logic ref_clk_i, // Clock
  input wire logic reset_i, // Async reset
  input wire logic wake_i, // Wake pin
  input wire logic [1:0] direct_input_pins_i, // Direct inputs
  input wire logic vdd_ok_i, // Logic supply good
  input wire logic [3:0] addr_i, // Index
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic [7:0] rdata_o, // Read data
  input wire logic [7:0] channel_o, // Channels
  input wire logic [1:0] mode_o, // State code
  input wire logic diag_en_o // Diagnosis
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Channel and diagnosis per state
  property p_sleep_off; mode_o == 2'h0 |-> channel_o == 8'h00; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("channel on in sleep");
  property p_idle_off; mode_o == 2'h2 |-> channel_o == 8'h00 && !diag_en_o; endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle drives or diagnoses");
  property p_fb_mask; mode_o == 2'h1 |-> (channel_o & 8'hf3) == 8'h00; endproperty
  a_fb_mask: assert property (p_fb_mask) else $error("fallback channel outside 2,3");
  // Read data stands one cycle only
  property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");
  // Write of a channel bit wakes the block two edges later
  property p_wr_act;
    mode_o == 2'h2 && wr_i && addr_i == 4'h0 && wdata_i != 8'h00 && vdd_ok_i && wake_i
      |-> ##2 mode_o == 2'h3;
  endproperty
  a_wr_act: assert property (p_wr_act) else $error("channel write did not activate");
  property p_fb_status; mode_o == 2'h1 && rd_i && addr_i == 4'h4 |=> rdata_o[3:0] == 4'hd;
  endproperty
  a_fb_status: assert property (p_fb_status) else $error("fallback status wrong");
  property p_fb_offload; mode_o == 2'h1 && rd_i && addr_i == 4'h6 |=> rdata_o == 8'h00;
  endproperty
  a_fb_offload: assert property (p_fb_offload) else $error("off-load bits in fallback");
  // Sync delay is about five edges, so eight quiet cycles must mean sleep
  property p_sleep_pins; (!wake_i && direct_input_pins_i == 2'h0) [*8] |-> mode_o == 2'h0;
  endproperty
  a_sleep_pins: assert property (p_sleep_pins) else $error("not asleep with pins low");
  c_active: cover property (mode_o == 2'h3);
  c_fb_on: cover property (mode_o == 2'h1 && channel_o != 8'h00);
  c_wake: cover property (mode_o == 2'h0 ##1 mode_o == 2'h2);
endmodule

/* dv/host_mcu_model.sv */
`timescale 1ns/1ps
// Host controller: register master and pin driver
module host_mcu_model (
  input wire logic clk_i, // Clock
  output logic [3:0] addr_o = 4'h0, // Index
  output logic [7:0] wdata_o = 8'h00, // Write data
  output logic wr_o = 1'b0, // Write strobe
  output logic rd_o = 1'b0, // Read strobe
  output logic wake_o = 1'b0, // Wake pin
  output logic [1:0] pins_o = 2'h0 // Direct inputs
);
  // One-cycle strobe; released bus is scrambled so stale values never pass
  task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clk_i);
    addr_o <= ~a;
    wdata_o <= ~d;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
  endtask
  // Pins move only while the bus is quiet
  task automatic pins(input logic w, input logic [1:0] p);
    @(posedge clk_i);
    wake_o <= w;
    pins_o <= p;
  endtask
endmodule

/* dv/test_switch_operation_mode_control.sv */
`timescale 1ns/1ps
// Scoreboarded run of the operating-state controller
module test_switch_operation_mode_control;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, vdd_ok_i = 1'b1, rd_seen = 1'b0;
  logic [7:0] err_set_i = 8'h00, off_load_i = 8'h00, monitor_i = 8'h00, r;
  logic wake_i, wr_i, rd_i, diag_en_o, power_on_o;
  logic [1:0] direct_input_pins_i, mode_o;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, channel_o;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int compares = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  host_mcu_model host_mcu_model_inst (.clk_i(ref_clk_i), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i), .wake_o(wake_i), .pins_o(direct_input_pins_i));
  switch_operation_mode_control switch_operation_mode_control_inst (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .wake_i(wake_i), .direct_input_pins_i(direct_input_pins_i),
    .vdd_ok_i(vdd_ok_i), .vdd_full_i(1'b1), .vs_ok_i(1'b1), .vs_uv_i(1'b0),
    .err_set_i(err_set_i), .off_load_i(off_load_i), .monitor_i(monitor_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .channel_o(channel_o),
    .mode_o(mode_o), .diag_en_o(diag_en_o), .power_on_o(power_on_o));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_mcu_model_inst.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_mcu_model_inst.access(1'b0, a, 8'h00);
  endtask
  task automatic give_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Read data settles one cycle after the strobe; compare mid-cycle
  always @(negedge ref_clk_i) begin
    if (rd_seen) check("rdata", rdata_o, exp_q.pop_front());
    rd_seen = rd_i;
  end
  // Main sequence: sleep, idle, active, soft reset, fallback, supply loss
  initial begin
    seed = lfsr(32'h5508e585);
    r = seed[7:0];
    cyc(12);
    reset_i <= 1'b0;
    off_load_i <= seed[15:8];
    monitor_i <= seed[23:16];
    rd(4'h4, 8'h00);
    #1 check("power_on", {7'h00, power_on_o}, 8'h00);
    host_mcu_model_inst.pins(1'b1, 2'h0);
    cyc(8);
    #1 check("power_on", {7'h00, power_on_o}, 8'h01);
    rd(4'h4, 8'h02);
    rd(4'h9, 8'h00);
    wr(4'h2, r);
    rd(4'h2, r);
    wr(4'h0, 8'h01);
    cyc(3);
    err_set_i <= 8'h20;
    #1 check("channel", channel_o, 8'h01);
    cyc(1);
    err_set_i <= 8'h00;
    rd(4'h4, 8'h03);
    wr(4'h0, 8'h00);
    cyc(3);
    rd(4'h4, 8'h02);
    rd(4'h5, 8'h20);
    // Stay-active only holds an active block, so wake it first
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h00);
    cyc(3);
    rd(4'h4, 8'h03);
    wr(4'h1, 8'h00);
    cyc(3);
    rd(4'h4, 8'h02);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    host_mcu_model_inst.pins(1'b1, 2'h1);
    cyc(8);
    rd(4'h4, 8'h03);
    host_mcu_model_inst.pins(1'b1, 2'h0);
    cyc(8);
    $display("active phase done");
    wr(4'h1, 8'h02);
    cyc(2);
    rd(4'h2, mode_ctrl_pkg::MAP_FIRST_RST);
    rd(4'h3, mode_ctrl_pkg::MAP_SECOND_RST);
    rd(4'h5, 8'h20);
    rd(4'h4, 8'h02);
    $display("soft reset done");
    host_mcu_model_inst.pins(1'b0, 2'h1);
    cyc(10);
    #1 check("channel", channel_o, 8'h04);
    rd(4'h4, 8'h1d);
    // The flag latched by the first command survives that read, set wins
    rd(4'h4, 8'h1d);
    rd(4'h4, 8'h0d);
    wr(4'h2, r);
    rd(4'h2, mode_ctrl_pkg::MAP_FIRST_RST);
    rd(4'h6, 8'h00);
    rd(4'h7, seed[23:16]);
    host_mcu_model_inst.pins(1'b0, 2'h0);
    cyc(10);
    rd(4'h4, 8'h00);
    $display("fallback done");
    host_mcu_model_inst.pins(1'b1, 2'h0);
    cyc(8);
    wr(4'h0, 8'h01);
    cyc(3);
    vdd_ok_i <= 1'b0;
    cyc(3);
    #1 check("mode", {6'h00, mode_o}, 8'h02);
    $display("supply loss done");
    give_verdict();
  end
  // Run needs well under 1000 cycles
  initial begin
    #50000;
    num_errors++;
    give_verdict();
  end
endmodule
bind switch_operation_mode_control mode_ctrl_chk mode_ctrl_chk_inst (.ref_clk_i(ref_clk_i),
  .reset_i(reset_i), .wake_i(wake_i), .direct_input_pins_i(direct_input_pins_i),
  .vdd_ok_i(vdd_ok_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .channel_o(channel_o), .mode_o(mode_o), .diag_en_o(diag_en_o));
